// ---- core/pin_sync.sv ----
// Two-stage synchroniser with edge detection for a vector of pins.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;
  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;

  always_comb begin
    meta_d = pin;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      prev_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule

// ---- core/voice_host_port.sv ----
// Host interface and voice memory pin logic of the voice synthesis device.
`timescale 1ns/1ps
// Operation
// - Memory address and enable driven while select low, else floated.
// - 24 address and 8 data lines reach 128 Mbits of memory.
// - Select pin marks each byte: high subcommand, low command.
// - Write strobes while chip select is high are ignored.
// - Strap high selects serial host mode, low selects parallel mode.
// - Parallel pins take data when writing, drive status when reading.
// - Serial mode takes command bits on shared bit-7 pin.
// - Host gives serial clock on bit-6 pin; device shifts data with it.
// - Serial mode drives channel status serially on bit-5 pin.
// - Bit-4 pin selects bank: high channels 8-5, low channels 4-1.
// - Status type pin high reports accept, low reports busy.
// - Reset low clears state, stops oscillator, grounds both D/A outputs.
// - A written phrase selection is an eight-bit index of 256 phrases.
// - Eight channels each keep a status indication for host readback.
module voice_host_port
  import voice_port_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic RESET_N,
  input wire logic SERIAL,
  input wire logic CS_N,
  input wire logic WR_N,
  input wire logic RD_N,
  input wire logic CMD,
  input wire logic STATUS_TYPE_SELECT,
  input wire logic [voice_port_pkg::HOST_W-1:0] HOST_DATA_IN,
  output logic [voice_port_pkg::HOST_W-1:0] HOST_DATA_OUT,
  output logic [voice_port_pkg::HOST_W-1:0] HOST_DATA_OE,
  input wire logic MEM_PORT_SELECT_N,
  output logic [voice_port_pkg::MEM_ADDR_W-1:0] VOICE_MEM_ADDR,
  output logic VOICE_MEM_ADDR_OE,
  output logic MEM_OUTPUT_ENABLE_N,
  output logic MEM_OUTPUT_ENABLE_OE,
  input wire logic [voice_port_pkg::MEM_DATA_W-1:0] VOICE_MEM_DATA,
  input wire logic [voice_port_pkg::MEM_ADDR_W-1:0] MEM_ADDR_REQ,
  input wire logic MEM_READ_REQ,
  output logic [voice_port_pkg::MEM_DATA_W-1:0] MEM_DATA_Q,
  input wire voice_port_pkg::chan_status_type CHAN_STATUS,
  output voice_port_pkg::host_cmd_type CMD_OUT,
  output logic CMD_VALID,
  output logic [voice_port_pkg::PHRASE_W-1:0] PHRASE_INDEX,
  input wire logic [voice_port_pkg::DA_W-1:0] DA_LEFT_IN,
  input wire logic [voice_port_pkg::DA_W-1:0] DA_RIGHT_IN,
  output logic [voice_port_pkg::DA_W-1:0] DA_LEFT,
  output logic [voice_port_pkg::DA_W-1:0] DA_RIGHT,
  output logic OSC_RUN,
  output logic SERIAL_MODE
);
  import voice_port_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [CHANNELS-1:0] pick_status(
    input logic accept_sel,
    input chan_status_type st
  );
    pick_status = accept_sel ? st.accept : st.busy;
  endfunction

  function automatic logic [BANK_W-1:0] pick_bank(
    input logic upper,
    input logic [CHANNELS-1:0] st
  );
    pick_bank = upper ? st[CHANNELS-1:BANK_W] : st[BANK_W-1:0];
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  logic [SYNC_W-1:0] sy_level;
  logic [SYNC_W-1:0] sy_rise;
  logic [SYNC_W-1:0] sy_fall;

  pin_sync #(
    .W(SYNC_W),
    .RST_VAL(SYNC_RST_VAL)
  ) u_sync (
    .clk(CLK),
    .rst(RST),
    .pin({MEM_PORT_SELECT_N, STATUS_TYPE_SELECT, CMD, RD_N, WR_N, CS_N,
          SERIAL, RESET_N, HOST_DATA_IN}),
    .level(sy_level),
    .rise(sy_rise),
    .fall(sy_fall)
  );

  logic [MEM_DATA_W-1:0] mdata_meta_q;
  logic [MEM_DATA_W-1:0] mdata_q;

  logic core_rst;
  logic [HOST_W-1:0] pin_data;
  logic cs_low;
  logic ser_clk_rise;
  logic ser_clk_fall;
  logic [CHANNELS-1:0] status_sel;

  assign core_rst = RST | ~sy_level[SY_RESET_N];
  assign pin_data = sy_level[SY_DATA +: HOST_W];
  assign cs_low = ~sy_level[SY_CS_N];
  assign ser_clk_rise = sy_rise[SY_DATA + PIN_SER_CLK];
  assign ser_clk_fall = sy_fall[SY_DATA + PIN_SER_CLK];
  assign status_sel = pick_status(sy_level[SY_STAT_TYPE],
                                  CHAN_STATUS);

  // ----------------------------------------------------------------------
  // Mode strap, caught while the device is held in reset
  // ----------------------------------------------------------------------
  mode_type mode_q;
  mode_type mode_d;

  always_comb begin
    mode_d = mode_q;
    if (core_rst) begin
      mode_d = sy_level[SY_SERIAL] ? MODE_SERIAL : MODE_PARALLEL;
    end
  end

  // ----------------------------------------------------------------------
  // Host command capture
  // ----------------------------------------------------------------------
  logic [HOST_W-1:0] shift_q;
  logic [HOST_W-1:0] shift_d;
  logic [SER_CNT_W-1:0] cnt_q;
  logic [SER_CNT_W-1:0] cnt_d;
  logic [HOST_W-1:0] so_sh_q;
  logic [HOST_W-1:0] so_sh_d;
  host_cmd_type cmd_q;
  host_cmd_type cmd_d;
  logic valid_q;
  logic valid_d;

  always_comb begin
    shift_d = shift_q;
    cnt_d = cnt_q;
    so_sh_d = so_sh_q;
    cmd_d = cmd_q;
    valid_d = 1'b0;
    unique case (mode_q)
      MODE_PARALLEL: begin
        if (sy_rise[SY_WR_N] && cs_low) begin
          cmd_d.value = pin_data;
          cmd_d.is_sub = sy_level[SY_CMD];
          valid_d = 1'b1;
        end
        cnt_d = '0;
      end
      MODE_SERIAL: begin
        if (!cs_low) begin
          cnt_d = '0;
          so_sh_d = status_sel;
        end else begin
          if (ser_clk_rise) begin
            shift_d = {shift_q[HOST_W-2:0],
                       pin_data[PIN_SER_DATA]};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == SER_LAST_BIT) begin
              cmd_d.value = {shift_q[HOST_W-2:0], pin_data[PIN_SER_DATA]};
              cmd_d.is_sub = sy_level[SY_CMD];
              valid_d = 1'b1;
            end
          end
          if (ser_clk_fall) begin
            so_sh_d = {so_sh_q[HOST_W-2:0], 1'b0};
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Host data pins
  // ----------------------------------------------------------------------
  logic [HOST_W-1:0] hout_q;
  logic [HOST_W-1:0] hout_d;
  logic [HOST_W-1:0] hoe;

  always_comb begin
    hout_d = '0;
    hoe = '0;
    unique case (mode_q)
      MODE_PARALLEL: begin
        hout_d = status_sel;
        if (!sy_level[SY_RD_N] && sy_level[SY_WR_N]) begin
          hoe = '1;
        end
      end
      MODE_SERIAL: begin
        hout_d[PIN_SER_STATUS] = so_sh_q[HOST_W-1];
        hout_d[BANK_W-1:0] = pick_bank(pin_data[PIN_BANK_SEL],
                                       status_sel);
        hoe = SER_OUT_MASK;
      end
    endcase
    if (core_rst) begin
      hoe = '0;
    end
  end

  // ----------------------------------------------------------------------
  // Voice memory port and analog side
  // ----------------------------------------------------------------------
  logic [MEM_ADDR_W-1:0] addr_q;
  logic [MEM_ADDR_W-1:0] addr_d;
  logic moe_n_q;
  logic moe_n_d;
  logic [DA_W-1:0] dal_q;
  logic [DA_W-1:0] dal_d;
  logic [DA_W-1:0] dar_q;
  logic [DA_W-1:0] dar_d;

  always_comb begin
    addr_d = MEM_ADDR_REQ;
    moe_n_d = ~MEM_READ_REQ;
    dal_d = DA_LEFT_IN;
    dar_d = DA_RIGHT_IN;
    if (core_rst) begin
      addr_d = ADDR_RST;
      moe_n_d = 1'b1;
      dal_d = DA_GND;
      dar_d = DA_GND;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic osc_q;

  always_ff @(posedge CLK) begin
    mdata_meta_q <= VOICE_MEM_DATA;
    mdata_q <= mdata_meta_q;
    if (RST) begin
      mode_q <= MODE_PARALLEL;
    end else begin
      mode_q <= mode_d;
    end
    if (core_rst) begin
      shift_q <= BYTE_RST;
      cnt_q <= '0;
      so_sh_q <= BYTE_RST;
      cmd_q <= '0;
      valid_q <= 1'b0;
      hout_q <= BYTE_RST;
      osc_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      so_sh_q <= so_sh_d;
      cmd_q <= cmd_d;
      valid_q <= valid_d;
      hout_q <= hout_d;
      osc_q <= 1'b1;
    end
    addr_q <= addr_d;
    moe_n_q <= moe_n_d;
    dal_q <= dal_d;
    dar_q <= dar_d;
  end

  assign HOST_DATA_OUT = hout_q;
  assign HOST_DATA_OE = hoe;
  assign VOICE_MEM_ADDR = addr_q;
  assign VOICE_MEM_ADDR_OE = ~sy_level[SY_MEM_SEL_N];
  assign MEM_OUTPUT_ENABLE_N = moe_n_q;
  assign MEM_OUTPUT_ENABLE_OE = ~sy_level[SY_MEM_SEL_N];
  assign MEM_DATA_Q = mdata_q;
  assign CMD_OUT = cmd_q;
  assign CMD_VALID = valid_q;
  assign PHRASE_INDEX = cmd_q.value;
  assign DA_LEFT = dal_q;
  assign DA_RIGHT = dar_q;
  assign OSC_RUN = osc_q;
  assign SERIAL_MODE = (mode_q == MODE_SERIAL);

endmodule

// ---- core/voice_port_pkg.sv ----
// Shared constants and types of the voice synthesis host and memory port.
package voice_port_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int HOST_W = 8;
  localparam int MEM_CAPACITY_MBIT = 128;
  localparam int MEM_DATA_W = 8;
  localparam int MEM_ADDR_W = $clog2(MEM_CAPACITY_MBIT * 1024 * 1024
                                     / MEM_DATA_W);
  localparam int CHANNELS = 8;
  localparam int BANK_W = 4;
  localparam int PHRASES = 256;
  localparam int PHRASE_W = $clog2(PHRASES);
  localparam int DA_W = 14;
  localparam int SER_CNT_W = 3;
  localparam logic [SER_CNT_W-1:0] SER_LAST_BIT = 3'h7;

  // ----------------------------------------------------------------------
  // Shared host pin positions in serial mode
  // ----------------------------------------------------------------------
  localparam int PIN_SER_DATA = 7;
  localparam int PIN_SER_CLK = 6;
  localparam int PIN_SER_STATUS = 5;
  localparam int PIN_BANK_SEL = 4;
  localparam logic [HOST_W-1:0] SER_OUT_MASK = 8'h2f;

  // ----------------------------------------------------------------------
  // Layout of the synchronised input vector
  // ----------------------------------------------------------------------
  localparam int SYNC_W = 16;
  localparam int SY_DATA = 0;
  localparam int SY_RESET_N = 8;
  localparam int SY_SERIAL = 9;
  localparam int SY_CS_N = 10;
  localparam int SY_WR_N = 11;
  localparam int SY_RD_N = 12;
  localparam int SY_CMD = 13;
  localparam int SY_STAT_TYPE = 14;
  localparam int SY_MEM_SEL_N = 15;
  localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 16'hbc00;

  // ----------------------------------------------------------------------
  // Reset values and types
  // ----------------------------------------------------------------------
  localparam logic [HOST_W-1:0] BYTE_RST = 8'h00;
  localparam logic [MEM_ADDR_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [DA_W-1:0] DA_GND = 14'h0000;

  typedef enum logic {
    MODE_PARALLEL = 1'b0,
    MODE_SERIAL = 1'b1
  } mode_type;

  typedef struct packed {
    logic is_sub;
    logic [HOST_W-1:0] value;
  } host_cmd_type;

  typedef struct packed {
    logic [CHANNELS-1:0] busy;
    logic [CHANNELS-1:0] accept;
  } chan_status_type;

endpackage

// ---- sim/voice_host_port_test.sv ----
// Self-checking bench of the voice host and memory port.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; \
  if ((a) !== (e)) begin n_errors++; \
  $display("ERROR %0t %h %h", $time, (a), (e)); end end
module voice_host_port_test;
  import voice_port_pkg::*;
  logic CLK = 0, RST = 1, RESET_N = 0, SERIAL = 0, CS_N = 1, WR_N = 1;
  logic RD_N = 1, CMD = 0, STATUS_TYPE_SELECT = 0, MEM_PORT_SELECT_N = 1;
  logic MEM_READ_REQ = 0, OSC_RUN, SERIAL_MODE, CMD_VALID;
  logic VOICE_MEM_ADDR_OE, MEM_OUTPUT_ENABLE_N, MEM_OUTPUT_ENABLE_OE;
  logic [7:0] HOST_DATA_IN = 8'h00, HOST_DATA_OUT, HOST_DATA_OE;
  logic [7:0] VOICE_MEM_DATA, MEM_DATA_Q, PHRASE_INDEX;
  logic [23:0] VOICE_MEM_ADDR, MEM_ADDR_REQ = 24'h000000;
  logic [13:0] DA_LEFT_IN = 14'h1abc, DA_RIGHT_IN = 14'h0f0f;
  logic [13:0] DA_LEFT, DA_RIGHT;
  chan_status_type CHAN_STATUS = 16'hc53a;
  host_cmd_type CMD_OUT;
  int n_errors = 0, checks = 0;
  voice_host_port dut_u (.CLK(CLK), .RST(RST), .RESET_N(RESET_N),
    .SERIAL(SERIAL), .CS_N(CS_N), .WR_N(WR_N), .RD_N(RD_N), .CMD(CMD),
    .STATUS_TYPE_SELECT(STATUS_TYPE_SELECT), .HOST_DATA_IN(HOST_DATA_IN),
    .HOST_DATA_OUT(HOST_DATA_OUT), .HOST_DATA_OE(HOST_DATA_OE),
    .MEM_PORT_SELECT_N(MEM_PORT_SELECT_N), .VOICE_MEM_ADDR(VOICE_MEM_ADDR),
    .VOICE_MEM_ADDR_OE(VOICE_MEM_ADDR_OE),
    .MEM_OUTPUT_ENABLE_N(MEM_OUTPUT_ENABLE_N),
    .MEM_OUTPUT_ENABLE_OE(MEM_OUTPUT_ENABLE_OE),
    .VOICE_MEM_DATA(VOICE_MEM_DATA), .MEM_ADDR_REQ(MEM_ADDR_REQ),
    .MEM_READ_REQ(MEM_READ_REQ), .MEM_DATA_Q(MEM_DATA_Q),
    .CHAN_STATUS(CHAN_STATUS), .CMD_OUT(CMD_OUT), .CMD_VALID(CMD_VALID),
    .PHRASE_INDEX(PHRASE_INDEX), .DA_LEFT_IN(DA_LEFT_IN),
    .DA_RIGHT_IN(DA_RIGHT_IN), .DA_LEFT(DA_LEFT), .DA_RIGHT(DA_RIGHT),
    .OSC_RUN(OSC_RUN), .SERIAL_MODE(SERIAL_MODE));
  voice_rom_model rom_u (.clk(CLK), .addr(VOICE_MEM_ADDR),
    .addr_oe(VOICE_MEM_ADDR_OE), .oe_n(MEM_OUTPUT_ENABLE_N),
    .oe_oe(MEM_OUTPUT_ENABLE_OE), .data(VOICE_MEM_DATA));
  initial begin
    forever #4 CLK = ~CLK;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic rst_dev(logic ser);
    SERIAL = ser;
    RST = 1;
    RESET_N = 0;
    cyc(10);
    RST = 0;
    cyc(6);
    `CHK(DA_LEFT, 14'h0000)
    `CHK(OSC_RUN, 1'b0)
    RESET_N = 1;
    cyc(8);
    `CHK(DA_RIGHT, DA_RIGHT_IN)
    `CHK(DA_LEFT, DA_LEFT_IN)
    `CHK(OSC_RUN, 1'b1)
    `CHK(SERIAL_MODE, ser)
  endtask
  task automatic tmem;
    MEM_PORT_SELECT_N = 0;
    MEM_ADDR_REQ = 24'hffffff;
    MEM_READ_REQ = 1;
    cyc(6);
    `CHK(VOICE_MEM_ADDR, 24'hffffff)
    `CHK(MEM_OUTPUT_ENABLE_N, 1'b0)
    `CHK(MEM_DATA_Q, 8'h5a)
    `CHK(MEM_OUTPUT_ENABLE_OE, 1'b1)
    MEM_READ_REQ = 0;
    MEM_PORT_SELECT_N = 1;
    cyc(6);
    `CHK(VOICE_MEM_ADDR_OE, 1'b0)
    `CHK(MEM_OUTPUT_ENABLE_OE, 1'b0)
  endtask
  task automatic pwr(logic c, logic [7:0] d, logic cs);
    int got;
    got = 0;
    CMD = c;
    HOST_DATA_IN = d;
    CS_N = cs;
    WR_N = 0;
    cyc(4);
    WR_N = 1;
    repeat (8) begin
      cyc(1);
      if (CMD_VALID === 1'b1) got++;
    end
    CS_N = 1;
    cyc(1);
    `CHK(got, int'(!cs))
    if (!cs) `CHK(CMD_OUT, {c, d})
    if (!cs) `CHK(PHRASE_INDEX, d)
  endtask
  task automatic prd;
    RD_N = 0;
    for (int t = 0; t < 2; t++) begin
      STATUS_TYPE_SELECT = t[0];
      cyc(6);
      `CHK(HOST_DATA_OUT, t ? 8'h3a : 8'hc5)
      `CHK(HOST_DATA_OE, 8'hff)
    end
    RD_N = 1;
    cyc(6);
    `CHK(HOST_DATA_OE, 8'h00)
  endtask
  task automatic swr(logic c, logic [7:0] d);
    int got;
    got = 0;
    CMD = c;
    CS_N = 0;
    cyc(4);
    for (int i = 7; i >= 0; i--) begin
      HOST_DATA_IN[7:6] = {d[i], 1'b0};
      cyc(4);
      HOST_DATA_IN[6] = 1;
      repeat (4) begin
        cyc(1);
        if (CMD_VALID === 1'b1) got++;
      end
      `CHK(HOST_DATA_OUT[5], CHAN_STATUS.accept[i])
    end
    HOST_DATA_IN[7:6] = {~d[0], 1'b0};
    repeat (8) begin
      cyc(1);
      if (CMD_VALID === 1'b1) got++;
    end
    CS_N = 1;
    cyc(1);
    `CHK(got, 1)
    `CHK(CMD_OUT, {c, d})
  endtask
  task automatic sstat;
    logic [7:0] s;
    for (int t = 0; t < 4; t++) begin
      s = t[1] ? 8'h3a : 8'hc5;
      STATUS_TYPE_SELECT = t[1];
      HOST_DATA_IN[4] = t[0];
      cyc(6);
      `CHK(HOST_DATA_OUT[3:0], t[0] ? s[7:4] : s[3:0])
      `CHK(HOST_DATA_OUT[5], s[7])
      `CHK(HOST_DATA_OE, 8'h2f)
    end
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_dev(1'b0);
    tmem;
    pwr(1'b0, 8'h25, 1'b0);
    pwr(1'b1, 8'hff, 1'b0);
    pwr(1'b0, 8'h11, 1'b1);
    prd;
    rst_dev(1'b1);
    swr(1'b0, 8'h08);
    swr(1'b1, 8'h82);
    sstat;
    wrap_up;
  end
  initial begin
    #100000;
    n_errors++;
    wrap_up;
  end
endmodule

// ---- sim/voice_port_checker.sv ----
// Pin-level assertions for the voice host and memory port.
`timescale 1ns/1ps
module voice_port_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic RESET_N,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic MEM_PORT_SELECT_N,
  input wire logic [voice_port_pkg::MEM_ADDR_W-1:0] VOICE_MEM_ADDR,
  input wire logic VOICE_MEM_ADDR_OE,
  input wire logic MEM_OUTPUT_ENABLE_OE,
  input wire logic [voice_port_pkg::MEM_ADDR_W-1:0] MEM_ADDR_REQ,
  input wire logic [voice_port_pkg::DA_W-1:0] DA_LEFT,
  input wire logic [voice_port_pkg::DA_W-1:0] DA_RIGHT,
  input wire logic OSC_RUN,
  input wire logic CMD_VALID,
  input wire logic [voice_port_pkg::HOST_W-1:0] HOST_DATA_OE,
  input wire logic SERIAL_MODE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_sel_steady;
    $stable(MEM_PORT_SELECT_N) [*4];
  endsequence
  sequence s_rd_held;
    (!SERIAL_MODE && RESET_N && !RD_N && WR_N) [*6];
  endsequence
  property p_sel;
    s_sel_steady |-> VOICE_MEM_ADDR_OE != MEM_PORT_SELECT_N;
  endproperty
  a_sel: assert property (p_sel) else $error("select not obeyed");
  property p_oe_pair;
    s_sel_steady |-> MEM_OUTPUT_ENABLE_OE != MEM_PORT_SELECT_N;
  endproperty
  a_oe_pair: assert property (p_oe_pair)
    else $error("output enable not obeyed");
  property p_addr;
    RESET_N && $past(RESET_N, 6) && !$past(RST)
      |-> VOICE_MEM_ADDR == $past(MEM_ADDR_REQ);
  endproperty
  a_addr: assert property (p_addr) else $error("address lost");
  property p_reset;
    (!RESET_N) [*5] |-> DA_LEFT == '0 && DA_RIGHT == '0 && !OSC_RUN;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset not held");
  property p_pulse;
    CMD_VALID |=> !CMD_VALID;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("valid too long");
  property p_cs;
    CS_N [*6] |-> !CMD_VALID;
  endproperty
  a_cs: assert property (p_cs) else $error("byte without select");
  property p_rd;
    s_rd_held |-> HOST_DATA_OE == 8'hff;
  endproperty
  a_rd: assert property (p_rd) else $error("read not driven");
  property p_ser;
    (SERIAL_MODE && RESET_N) [*6] |-> HOST_DATA_OE == 8'h2f;
  endproperty
  a_ser: assert property (p_ser) else $error("serial pins wrong");
endmodule
bind voice_host_port voice_port_checker chk_u (.CLK(CLK), .RST(RST),
  .RESET_N(RESET_N), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N),
  .MEM_PORT_SELECT_N(MEM_PORT_SELECT_N), .VOICE_MEM_ADDR(VOICE_MEM_ADDR),
  .VOICE_MEM_ADDR_OE(VOICE_MEM_ADDR_OE),
  .MEM_OUTPUT_ENABLE_OE(MEM_OUTPUT_ENABLE_OE),
  .MEM_ADDR_REQ(MEM_ADDR_REQ), .DA_LEFT(DA_LEFT), .DA_RIGHT(DA_RIGHT),
  .OSC_RUN(OSC_RUN), .CMD_VALID(CMD_VALID), .HOST_DATA_OE(HOST_DATA_OE),
  .SERIAL_MODE(SERIAL_MODE));

// ---- sim/voice_rom_model.sv ----
// Voice data memory model answering the device's memory pins.
`timescale 1ns/1ps
module voice_rom_model (
  input wire logic clk,
  input wire logic [23:0] addr,
  input wire logic addr_oe,
  input wire logic oe_n,
  input wire logic oe_oe,
  output logic [7:0] data
);
  logic [7:0] last_q;
  always_ff @(posedge clk) begin
    last_q <= data;
  end
  // A memory with pins driven and output enable high leaves changing noise so stale data never looks valid.
  always_comb begin
    if (!addr_oe || !oe_oe) begin
      data = 8'h00;
    end else if (!oe_n) begin
      data = addr[7:0] ^ 8'ha5;
    end else begin
      data = ~last_q;
    end
  end
endmodule
